// [verilog/dacurc_control.sv]
// Update and reset control of a 16-channel DAC.
// Behaviour
// - Frame is 24 bits: code, channel, payload.
// - Code 0101 loads 16-bit mask, address ignored.
// - Mask bits reset to zero.
// - Masked channel ignores load strobe transitions.
// - Strobe falling edge copies unmasked channels.
// - Strobe held low ignores mask, writes update.
// - Code 0001 writes input; DAC only if low.
// - Code 0010 copies input into DAC register.
// - Code 0011 writes input and DAC register.
// - Reset pin clears outputs to power-up code.
// - Reset low blocks updates; hold after release.
// - Pins ignored during power-on reset.
// - Reset pin low postpones initialisation.
// - Outputs start at power-up code.
// - Code 0110 resets only with 0x0, 0x1234.
// - Code 0111 writes reference setup register.
// - Reference bit 0 low enables reference.
// - Held-low write updates on 24th bit.
`timescale 1ns/100ps
module dacurc_control #(
  parameter bit          MIDSCALE   = 1'b0,
  parameter int unsigned POR_CYCLES = dacurc_pkg::POR_CYCLES
) (
  // Clock and power-on reset.
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Completed frames from the serial front end.
  input  wire logic                     frameValid,
  input  wire dacurc_pkg::dacurc_frame_t frame,
  // Device pins.
  input  wire logic                     loadStrobeN,
  input  wire logic                     resetPinN,
  // Register contents and status.
  output logic [dacurc_pkg::NUM_CH-1:0][dacurc_pkg::CODE_W-1:0] inputCode,
  output logic [dacurc_pkg::NUM_CH-1:0][dacurc_pkg::CODE_W-1:0] dacCode,
  output logic [dacurc_pkg::NUM_CH-1:0] loadMask,
  output logic [dacurc_pkg::REF_W-1:0]  refSetup,
  output logic                          refOff,
  output logic                          ready
);

  localparam logic [15:0] RESET_CODE =
    MIDSCALE ? dacurc_pkg::MID_CODE : dacurc_pkg::ZERO_CODE;

  logic                     ldSync1_reg;
  logic                     ldSync2_reg;
  logic                     ldPrev_reg;
  logic                     rsSync1_reg;
  logic                     rsSync2_reg;
  dacurc_pkg::dacurc_por_t  por_reg;
  dacurc_pkg::dacurc_por_t  por_next;
  logic [15:0]              porCnt_reg;
  logic [15:0]              porCnt_next;
  logic                     ready_reg;
  logic                     ready_next;
  logic [15:0]              mask_reg;
  logic [15:0]              mask_next;
  logic [2:0]               ref_reg;
  logic [2:0]               ref_next;
  logic                     ldFall;
  logic                     live;
  logic                     accept;
  logic                     swReset;
  logic [3:0]               cmd;
  logic [3:0]               chSel;
  logic [15:0]              payload;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ldSync1_reg <= 1'b1;
      ldSync2_reg <= 1'b1;
      ldPrev_reg  <= 1'b1;
      // The reset pin counts as low until it has been seen high.
      rsSync1_reg <= 1'b0;
      rsSync2_reg <= 1'b0;
    end
    else
    begin
      ldSync1_reg <= loadStrobeN;
      ldSync2_reg <= ldSync1_reg;
      ldPrev_reg  <= ldSync2_reg;
      rsSync1_reg <= resetPinN;
      rsSync2_reg <= rsSync1_reg;
    end
  end

  // Falling edge of the synchronised strobe.
  assign ldFall = ldPrev_reg & ~ldSync2_reg;

  //////////////////////////////////////////////////////////////////////////
  // Power-on sequencer; waits for the reset pin, then counts.
  always_comb
  begin
    por_next    = por_reg;
    porCnt_next = porCnt_reg;
    case (por_reg)
      dacurc_pkg::POR_HOLD:
      begin
        porCnt_next = 16'h0000;
        if (rsSync2_reg)
          por_next = dacurc_pkg::POR_RUN;
      end
      dacurc_pkg::POR_RUN:
      begin
        porCnt_next = porCnt_reg + 16'h0001;
        if (porCnt_reg == 16'(POR_CYCLES - 1))
          por_next = dacurc_pkg::POR_READY;
      end
      dacurc_pkg::POR_READY:
        por_next = dacurc_pkg::POR_READY;
      default:
        por_next = dacurc_pkg::POR_HOLD;
    endcase
    ready_next = (por_next == dacurc_pkg::POR_READY);
  end

  // Registers the sequencer.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      por_reg    <= dacurc_pkg::POR_HOLD;
      porCnt_reg <= 16'h0000;
      ready_reg  <= 1'b0;
    end
    else
    begin
      por_reg    <= por_next;
      porCnt_reg <= porCnt_next;
      ready_reg  <= ready_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame decode; frames count only once ready and with reset pin high.
  assign cmd     = frame.commandCodeBits;
  assign chSel   = frame.channelSelectBits;
  assign payload = frame.payload;
  assign live    = ready_reg & rsSync2_reg;
  assign accept  = frameValid & live;
  assign swReset = accept & (cmd == dacurc_pkg::CMD_SW_RST)
                 & (chSel == dacurc_pkg::SW_RST_ADDR)
                 & (payload == dacurc_pkg::SW_RST_KEY);

  // Mask and reference setup registers.
  always_comb
  begin
    mask_next = mask_reg;
    ref_next  = ref_reg;
    if (swReset)
    begin
      mask_next = dacurc_pkg::MASK_RESET;
      ref_next  = dacurc_pkg::REF_RESET;
    end
    else if (accept && cmd == dacurc_pkg::CMD_MASK)
      mask_next = payload;
    else if (accept && cmd == dacurc_pkg::CMD_REF)
      ref_next = payload[2:0];
  end

  // Registers mask and reference setup.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mask_reg <= dacurc_pkg::MASK_RESET;
      ref_reg  <= dacurc_pkg::REF_RESET;
    end
    else
    begin
      mask_reg <= mask_next;
      ref_reg  <= ref_next;
    end
  end

  assign loadMask = mask_reg;
  assign refSetup = ref_reg;
  assign refOff   = ref_reg[dacurc_pkg::REF_OFF_BIT];
  assign ready    = ready_reg;

  //////////////////////////////////////////////////////////////////////////
  // Channel registers with their update controls.
  for (genvar g = 0; g < dacurc_pkg::NUM_CH; g++)
  begin : gCh
    logic sel;
    logic clr;
    logic wrIn;
    logic wrDac;
    logic cpy;
    assign sel   = accept & (chSel == 4'(g));
    assign clr   = ~live | swReset;
    assign wrIn  = sel & (cmd == dacurc_pkg::CMD_WR_INPUT
                        | cmd == dacurc_pkg::CMD_WR_UPD);
    assign wrDac = sel & (cmd == dacurc_pkg::CMD_WR_UPD
                        | (cmd == dacurc_pkg::CMD_WR_INPUT
                           & ~ldSync2_reg));
    assign cpy   = (sel & (cmd == dacurc_pkg::CMD_UPD_DAC))
                 | (ldFall & live & ~mask_reg[g]);
    dacurc_channel #(
      .RESET_CODE (RESET_CODE)
    ) uChannel (
      .clk       (clk),
      .rst_b     (rst_b),
      .clear     (clr),
      .wrInput   (wrIn),
      .wrDac     (wrDac),
      .copyDac   (cpy),
      .data      (payload),
      .inputCode (inputCode[g]),
      .dacCode   (dacCode[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on channel 0 and the control registers.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic acc0;
  assign acc0 = accept & (chSel == 4'h0);

  property p_mask_load;
    accept && cmd == dacurc_pkg::CMD_MASK && !swReset
      |=> loadMask == $past(payload);
  endproperty
  a_mask_load: assert property (p_mask_load)
    else $error("Mask not loaded from payload.");

  property p_mask_reset;
    $rose(ready_reg) |-> loadMask == dacurc_pkg::MASK_RESET;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("Mask not zero after power-up.");

  property p_masked;
    ldFall && live && mask_reg[0] && !acc0 |=> $stable(dacCode[0]);
  endproperty
  a_masked: assert property (p_masked)
    else $error("Masked channel followed the strobe.");

  property p_fall_copy;
    ldFall && live && !mask_reg[0] && !acc0 && !swReset
      |=> dacCode[0] == $past(inputCode[0]);
  endproperty
  a_fall_copy: assert property (p_fall_copy)
    else $error("Strobe edge did not copy input.");

  property p_held_low;
    acc0 && cmd == dacurc_pkg::CMD_WR_INPUT && !ldSync2_reg
      |=> dacCode[0] == $past(payload) && inputCode[0] == $past(payload);
  endproperty
  a_held_low: assert property (p_held_low)
    else $error("Write with strobe low missed DAC.");

  property p_wr_high;
    acc0 && cmd == dacurc_pkg::CMD_WR_INPUT && ldSync2_reg && !ldFall
      |=> $stable(dacCode[0]) && inputCode[0] == $past(payload);
  endproperty
  a_wr_high: assert property (p_wr_high)
    else $error("Write with strobe high touched DAC.");

  property p_upd;
    acc0 && cmd == dacurc_pkg::CMD_UPD_DAC
      |=> $stable(inputCode[0]) && dacCode[0] == $past(inputCode[0]);
  endproperty
  a_upd: assert property (p_upd)
    else $error("Update command failed.");

  property p_wr_upd;
    acc0 && cmd == dacurc_pkg::CMD_WR_UPD
      |=> dacCode[0] == $past(payload) && inputCode[0] == $past(payload);
  endproperty
  a_wr_upd: assert property (p_wr_upd)
    else $error("Write and update failed.");

  property p_rst_pin;
    ready_reg && !rsSync2_reg |=> dacCode[0] == RESET_CODE [*2];
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("Reset pin did not hold the clear code.");

  property p_por_hold;
    por_reg == dacurc_pkg::POR_HOLD && !rsSync2_reg
      |=> por_reg == dacurc_pkg::POR_HOLD && !ready_reg;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("Initialisation ran with reset pin low.");

  property p_por_code;
    $rose(ready_reg) |-> dacCode[0] == RESET_CODE;
  endproperty
  a_por_code: assert property (p_por_code)
    else $error("Output not at power-up code.");

  property p_sw_rst;
    swReset |=> loadMask == dacurc_pkg::MASK_RESET
      && dacCode[0] == RESET_CODE && refSetup == dacurc_pkg::REF_RESET;
  endproperty
  a_sw_rst: assert property (p_sw_rst)
    else $error("Software reset failed.");

  property p_ref;
    accept && cmd == dacurc_pkg::CMD_REF
      |=> refSetup == $past(payload[2:0]) && refOff == $past(payload[0]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("Reference setup not written.");

  // Main scenarios.
  c_fall: cover property (ldFall && live && mask_reg != 16'h0000);
  c_sw_rst: cover property (swReset);
  c_wr_upd: cover property (acc0 && cmd == dacurc_pkg::CMD_WR_UPD);
  c_ready: cover property ($rose(ready_reg));

endmodule

// [verilog/dacurc_pkg.sv]
// Constants and types shared by the DAC update and reset control.
package dacurc_pkg;

  // Channel count and code width.
  localparam int NUM_CH = 16;
  localparam int CODE_W = 16;
  localparam int REF_W  = 3;

  // Command codes carried in the top nibble of a frame.
  localparam logic [3:0] CMD_WR_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPD_DAC  = 4'h2;
  localparam logic [3:0] CMD_WR_UPD   = 4'h3;
  localparam logic [3:0] CMD_MASK     = 4'h5;
  localparam logic [3:0] CMD_SW_RST   = 4'h6;
  localparam logic [3:0] CMD_REF      = 4'h7;

  // Software reset executes only with this address and key.
  localparam logic [3:0]  SW_RST_ADDR = 4'h0;
  localparam logic [15:0] SW_RST_KEY  = 16'h1234;

  // Values after reset.
  localparam logic [15:0]      MASK_RESET = 16'h0000;
  localparam logic [REF_W-1:0] REF_RESET  = 3'h0;
  localparam int               REF_OFF_BIT = 0;
  localparam logic [15:0]      ZERO_CODE  = 16'h0000;
  localparam logic [15:0]      MID_CODE   = 16'h8000;

  // Power-on initialisation time and its cycle count at 100 MHz.
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_NS   = 100;
  localparam int POR_CYCLES    =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power-on sequencer states.
  typedef enum logic [1:0] {
    POR_HOLD  = 2'b00,
    POR_RUN   = 2'b01,
    POR_READY = 2'b10
  } dacurc_por_t;

  // One 24-bit command frame: code, channel select, payload.
  typedef struct packed {
    logic [3:0]  commandCodeBits;
    logic [3:0]  channelSelectBits;
    logic [15:0] payload;
  } dacurc_frame_t;

endpackage

// [verilog/dacurc_channel.sv]
// One channel: an input register and a DAC register.
`timescale 1ns/100ps
module dacurc_channel #(
  parameter logic [15:0] RESET_CODE = 16'h0000
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Update controls.
  input  wire logic        clear,
  input  wire logic        wrInput,
  input  wire logic        wrDac,
  input  wire logic        copyDac,
  input  wire logic [15:0] data,
  // Register contents.
  output logic      [15:0] inputCode,
  output logic      [15:0] dacCode
);

  logic [15:0] input_reg;
  logic [15:0] input_next;
  logic [15:0] dac_reg;
  logic [15:0] dac_next;

  // Clear wins; a direct write wins over a copy from the input register.
  always_comb
  begin
    input_next = input_reg;
    dac_next   = dac_reg;
    if (clear)
    begin
      input_next = RESET_CODE;
      dac_next   = RESET_CODE;
    end
    else
    begin
      if (wrInput)
        input_next = data;
      if (wrDac)
        dac_next = data;
      else if (copyDac)
        dac_next = input_reg;
    end
  end

  // Registers the channel state.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      input_reg <= RESET_CODE;
      dac_reg   <= RESET_CODE;
    end
    else
    begin
      input_reg <= input_next;
      dac_reg   <= dac_next;
    end
  end

  assign inputCode = input_reg;
  assign dacCode   = dac_reg;

endmodule

// [test/dacurc_host_model.sv]
// Host model that turns three command bytes into one frame.
`timescale 1ns/100ps
module dacurc_host_model (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Command bytes from the bench and the reply lag.
  input  wire logic                 sendReq,
  input  wire logic [7:0]           cmdByte,
  input  wire logic [7:0]           msbByte,
  input  wire logic [7:0]           lsbByte,
  input  wire logic [1:0]           lag,
  // Frame towards the control block.
  output logic                      frameValid,
  output dacurc_pkg::dacurc_frame_t frame
);
  logic [1:0] stepReg;
  logic       busyReg;

  //////////////////////////////////////////////////////////////////////////
  // Waits lag cycles, then shows the frame for one cycle; idle lines toggle.
  always_ff @(posedge clk)
  begin
    frameValid <= 1'b0;
    frame      <= ~frame;
    if (!rst_b)
    begin
      busyReg <= 1'b0;
      frame   <= 24'h00_0000;
    end
    else if (sendReq && !busyReg)
    begin
      busyReg <= 1'b1;
      stepReg <= lag;
    end
    else if (busyReg && stepReg != 2'h0)
      stepReg <= stepReg - 2'h1;
    else if (busyReg)
    begin
      busyReg    <= 1'b0;
      frameValid <= 1'b1;
      frame      <= {cmdByte, msbByte, lsbByte};
    end
  end
endmodule

// [test/tb_dac_update_reset_control.sv]
// Self-checking bench of the DAC update and reset control.
`timescale 1ns/100ps
module tb_dac_update_reset_control;
  localparam int          POR = 4;
  localparam logic [15:0] PUP = dacurc_pkg::MID_CODE;
  logic                      clk         = 1'b0;
  logic                      rst_b       = 1'b0;
  logic                      loadStrobeN = 1'b1;
  logic                      resetPinN   = 1'b0;
  logic                      sendReq     = 1'b0;
  logic [7:0]                cmdByte     = 8'h00;
  logic [7:0]                msbByte     = 8'h00;
  logic [7:0]                lsbByte     = 8'h00;
  logic [1:0]                lag         = 2'h0;
  logic                      frameValid;
  dacurc_pkg::dacurc_frame_t frame;
  logic [15:0][15:0]         inputCode;
  logic [15:0][15:0]         dacCode;
  logic [15:0]               loadMask;
  logic [2:0]                refSetup;
  logic                      refOff;
  logic                      ready;
  int                        fails    = 0;
  int                        compares = 0;
  int                        cycles   = 0;

  // Block under test and the host model in front of it.
  dacurc_control #(.MIDSCALE(1'b1), .POR_CYCLES(POR)) dacurc_control_inst (
    .clk, .rst_b, .frameValid, .frame, .loadStrobeN, .resetPinN,
    .inputCode, .dacCode, .loadMask, .refSetup, .refOff, .ready);
  dacurc_host_model dacurc_host_model_inst (
    .clk, .rst_b, .sendReq, .cmdByte, .msbByte, .lsbByte, .lag,
    .frameValid, .frame);

  //////////////////////////////////////////////////////////////////////////
  // Clock and the cycle ceiling that cuts a hang short.
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      print_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare tasks and bus helpers.
  task automatic check_code(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_chan(input int c, input logic [15:0] i,
                            input logic [15:0] d);
    check_code(inputCode[c], i);
    check_code(dacCode[c], d);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Holds the request until the frame shows, then lets the block take it.
  task automatic send(input logic [3:0] cmd, input logic [3:0] ch,
                      input logic [15:0] data, input logic [1:0] l);
    int n;
    n = 0;
    sendReq = 1'b1;
    cmdByte = {cmd, ch};
    msbByte = data[15:8];
    lsbByte = data[7:0];
    lag = l;
    while (frameValid !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    check_flag(frameValid, 1'b1);
    sendReq = 1'b0;
    step(1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_power_up();
    int n;
    n = 0;
    step(2);
    rst_b = 1'b1;
    for (int c = 0; c < 16; c++) check_chan(c, PUP, PUP);
    check_code(loadMask, 16'h0000);
    check_flag(refOff, 1'b0);
    loadStrobeN = 1'b0;
    send(dacurc_pkg::CMD_WR_UPD, 4'h1, 16'h5555, 2'h0);
    step(20);
    check_flag(ready, 1'b0);
    check_chan(1, PUP, PUP);
    loadStrobeN = 1'b1;
    resetPinN = 1'b1;
    while (ready !== 1'b1 && n < POR + 8)
    begin
      step(1);
      n++;
    end
    check_flag(ready, 1'b1);
  endtask

  task automatic t_write_modes();
    send(dacurc_pkg::CMD_WR_INPUT, 4'h0, 16'h1111, 2'h2);
    check_chan(0, 16'h1111, PUP);
    send(dacurc_pkg::CMD_UPD_DAC, 4'h0, 16'h0000, 2'h0);
    check_chan(0, 16'h1111, 16'h1111);
    send(dacurc_pkg::CMD_WR_UPD, 4'h5, 16'h2222, 2'h1);
    check_chan(5, 16'h2222, 16'h2222);
    send(dacurc_pkg::CMD_WR_UPD, 4'h0, 16'h2222, 2'h0);
    check_chan(0, 16'h2222, 16'h2222);
    send(4'h4, 4'h5, 16'h0F0F, 2'h0);
    check_chan(5, 16'h2222, 16'h2222);
  endtask

  task automatic t_mask();
    send(dacurc_pkg::CMD_MASK, 4'h9, 16'h00F1, 2'h0);
    check_code(loadMask, 16'h00F1);
    send(dacurc_pkg::CMD_WR_INPUT, 4'h4, 16'hAAAA, 2'h0);
    send(dacurc_pkg::CMD_WR_INPUT, 4'h8, 16'hBBBB, 2'h0);
    send(dacurc_pkg::CMD_WR_INPUT, 4'h0, 16'hCCCC, 2'h0);
    loadStrobeN = 1'b0;
    step(4);
    check_chan(4, 16'hAAAA, PUP);
    check_chan(0, 16'hCCCC, 16'h2222);
    check_chan(8, 16'hBBBB, 16'hBBBB);
    send(dacurc_pkg::CMD_WR_INPUT, 4'h0, 16'h3333, 2'h0);
    check_chan(0, 16'h3333, 16'h3333);
    loadStrobeN = 1'b1;
    step(3);
  endtask

  task automatic t_soft_reset();
    send(dacurc_pkg::CMD_SW_RST, 4'h1, 16'h1234, 2'h0);
    check_chan(8, 16'hBBBB, 16'hBBBB);
    send(dacurc_pkg::CMD_SW_RST, 4'h0, 16'h1235, 2'h0);
    check_chan(8, 16'hBBBB, 16'hBBBB);
    send(dacurc_pkg::CMD_SW_RST, 4'h0, 16'h1234, 2'h0);
    check_chan(8, PUP, PUP);
    check_code(loadMask, 16'h0000);
  endtask

  task automatic t_reference();
    send(dacurc_pkg::CMD_REF, 4'hC, 16'h0001, 2'h0);
    check_code({13'h0000, refSetup}, 16'h0001);
    check_flag(refOff, 1'b1);
    send(dacurc_pkg::CMD_REF, 4'h0, 16'h0000, 2'h0);
    check_flag(refOff, 1'b0);
  endtask

  task automatic t_reset_pin();
    send(dacurc_pkg::CMD_WR_UPD, 4'h2, 16'h4444, 2'h0);
    check_chan(2, 16'h4444, 16'h4444);
    resetPinN = 1'b0;
    step(4);
    check_chan(2, PUP, PUP);
    send(dacurc_pkg::CMD_WR_UPD, 4'h2, 16'h7777, 2'h0);
    check_chan(2, PUP, PUP);
    resetPinN = 1'b1;
    step(4);
    check_chan(2, PUP, PUP);
    // New data and a strobe edge are taken again after release.
    send(dacurc_pkg::CMD_WR_INPUT, 4'h0, 16'h6666, 2'h0);
    check_chan(0, 16'h6666, PUP);
    loadStrobeN = 1'b0;
    step(4);
    check_chan(0, 16'h6666, 16'h6666);
    loadStrobeN = 1'b1;
    step(3);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    t_power_up();
    t_write_modes();
    t_mask();
    t_soft_reset();
    t_reference();
    t_reset_pin();
    print_verdict();
  end
endmodule
